// *** dv/ext_block.sv ***
// Stand-in for another function block exporting its actual value
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Actual value source
module ext_block #(
    parameter int ACTUAL = 160
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    output ramp_pkg::level_t actual_q
);
    // Value only valid once out of reset, like a real block
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            actual_q <= '0;
        else
            actual_q <= ramp_pkg::level_t'(ACTUAL);
    end
endmodule
`default_nettype wire

// *** dv/level_ramp_bench.sv ***
// Self-checking bench for the level ramp
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Stimulus and checks
module level_ramp_bench;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic             enable, soft_halt, level_choice, rerr;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rdata;
    logic [15:0]      scaled_output;
    ramp_pkg::level_t current_level, actual;
    int               n_mismatch = 0;
    int               n_compared = 0;
    // Short tick keeps the run small
    level_ramp #(.TICK_CYCLES(50)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enable(enable), .soft_halt(soft_halt),
        .level_choice(level_choice), .target_one_ext(actual),
        .target_two_ext(actual), .current_level(current_level),
        .scaled_output(scaled_output));
    ext_block u_ext (.pclk(pclk), .presetn(presetn), .actual_q(actual));
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic end_of_test();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One APB transfer; idles a cycle so strobes never toggle twice
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Registered outputs read at the edge still hold the access value
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Wait n edges, then look at settled outputs mid-cycle
    task automatic at(input int n, input logic [31:0] l,
                      input logic [31:0] o, input logic co);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        chk(32'(current_level), l);
        if (co)
            chk({16'h0, scaled_output}, o);
        @(posedge pclk);
    endtask
    initial
    begin
        #40000;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        {psel, penable, pwrite, enable, soft_halt, level_choice} = '0;
        paddr = '0;
        pwdata = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ramp_pkg::ADDR_RATE, 32'h0);
        chk(rdata, 32'h0000000a);
        apb(1'b0, ramp_pkg::ADDR_CEILING, 32'h0);
        chk(rdata, 32'h00004e20);
        apb(1'b0, 8'h2c, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, ramp_pkg::ADDR_TARGET2, 32'h7530);
        apb(1'b0, ramp_pkg::ADDR_TARGET2, 32'h0);
        chk(rdata, 32'h00004e20);
        apb(1'b1, ramp_pkg::ADDR_LAUNCH, 32'h64);
        apb(1'b1, ramp_pkg::ADDR_RATE, 32'h64);
        apb(1'b1, ramp_pkg::ADDR_TARGET1, 32'h87);
        enable <= 1'b1;
        at(2, 32'h64, 32'h0, 1'b0);
        at(330, 32'h87, 32'h87, 1'b1);
        apb(1'b1, ramp_pkg::ADDR_GAIN, 32'hc8);
        apb(1'b1, ramp_pkg::ADDR_CEILING, 32'h96);
        apb(1'b1, ramp_pkg::ADDR_CTRL, 32'h2);
        level_choice <= 1'b1;
        at(300, 32'h96, 32'h4b, 1'b1);
        soft_halt <= 1'b1;
        at(400, 32'h0, 32'h0, 1'b1);
        enable <= 1'b0;
        at(2, 32'h0, 32'h0, 1'b0);
        enable <= 1'b1;
        at(3, 32'h0, 32'h0, 1'b0);
        soft_halt <= 1'b0;
        enable <= 1'b0;
        at(2, 32'h0, 32'h0, 1'b0);
        enable <= 1'b1;
        at(2, 32'h64, 32'h0, 1'b0);
        at(120, 32'h6e, 32'h0, 1'b0);
        enable <= 1'b0;
        at(1, 32'h0, 32'h0, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire

// *** dv/ramp_checker.sv ***
// Port assertions for the level ramp
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Checker
module ramp_checker (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              enable,
    input wire logic              soft_halt,
    input wire ramp_pkg::level_t  current_level,
    input wire logic [15:0]       scaled_output
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Zero-wait slave: one ready pulse per access
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_err_unmapped: assert property (pready && (paddr > 8'h28
        || paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pready && paddr <= 8'h28
        && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    // Ramp outputs, bounded whatever the parameters; level held in the first cycles of the start dwell
    a_out_range: assert property (scaled_output <= 16'h7fff)
        else $error("scaled output above limit");
    a_level_ceiling: assert property (current_level <= 18'sd20000)
        else $error("level above ceiling range");
    a_start_hold: assert property (
        $rose(enable) |=> ##2 $stable(current_level)[*8])
        else $error("level moved in start dwell");
    cover property ($rose(enable));
    cover property ($rose(soft_halt));
    cover property (pready && pslverr);
endmodule
bind level_ramp ramp_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable(enable),
    .soft_halt(soft_halt), .current_level(current_level),
    .scaled_output(scaled_output));
`default_nettype wire

// *** verilog/level_ramp.sv ***
// Level ramp generator with APB parameter registers and scaled output
`timescale 1ns/1ps
`default_nettype none
module level_ramp #(
    parameter int unsigned TICK_CYCLES = ramp_pkg::TICK_CYCLES
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         enable,
    input  wire logic                         soft_halt,
    input  wire logic                         level_choice,
    input  wire ramp_pkg::level_t             target_one_ext,
    input  wire ramp_pkg::level_t             target_two_ext,
    output ramp_pkg::level_t                  current_level,
    output logic [ramp_pkg::OUT_W-1:0]        scaled_output
);

    // ==========================================================
    // Helpers
    // ==========================================================
    // Saturate a written word into a signed range
    function automatic ramp_pkg::level_t clamp_level(
        input logic [31:0] v, input int lo, input int hi);
        int s;
        s = int'(v);
        if (s < lo)
            s = lo;
        if (s > hi)
            s = hi;
        return ramp_pkg::level_t'(s);
    endfunction

    // Move one step toward a target without passing it
    function automatic ramp_pkg::level_t step_toward(
        input ramp_pkg::level_t cur,
        input ramp_pkg::level_t tgt,
        input ramp_pkg::level_t stp);
        ramp_pkg::level_t res;
        res = tgt;
        if (cur < tgt && (tgt - cur) > stp)
            res = cur + stp;
        else if (cur > tgt && (cur - tgt) > stp)
            res = cur - stp;
        return res;
    endfunction

    // ==========================================================
    // APB slave
    // ==========================================================
    ramp_pkg::ramp_params_t prm_q;
    ramp_pkg::ramp_state_t  state_q;
    logic                   halt_lock_q;
    logic                   wr_en;
    logic                   rd_hit;
    logic [31:0]            rd_data;

    // Zero-wait slave: pready rises in the first access cycle
    assign wr_en = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= psel && !penable && !pready;
    end

    // Parameter writes, clamped to their legal ranges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prm_q                     <= '0;
            prm_q.level_ceiling       <= ramp_pkg::RST_CEILING;
            prm_q.rate                <= ramp_pkg::RST_RATE;
            prm_q.gain                <= ramp_pkg::RST_GAIN;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                ramp_pkg::ADDR_CTRL:
                begin
                    prm_q.src1_ext <= pwdata[ramp_pkg::CTRL_SRC1_BIT];
                    prm_q.src2_ext <= pwdata[ramp_pkg::CTRL_SRC2_BIT];
                end
                ramp_pkg::ADDR_TARGET1:
                    prm_q.target_one <= clamp_level(pwdata,
                        ramp_pkg::TARGET_MIN, ramp_pkg::TARGET_MAX);
                ramp_pkg::ADDR_TARGET2:
                    prm_q.target_two <= clamp_level(pwdata,
                        ramp_pkg::TARGET_MIN, ramp_pkg::TARGET_MAX);
                ramp_pkg::ADDR_CEILING:
                    prm_q.level_ceiling <= clamp_level(pwdata,
                        ramp_pkg::TARGET_MIN, ramp_pkg::TARGET_MAX);
                ramp_pkg::ADDR_LAUNCH:
                    prm_q.launch_floor_offset <= clamp_level(pwdata,
                        ramp_pkg::LAUNCH_MIN, ramp_pkg::LAUNCH_MAX);
                ramp_pkg::ADDR_RATE:
                    prm_q.rate <= ramp_pkg::RATE_W'(clamp_level(pwdata,
                        ramp_pkg::RATE_MIN, ramp_pkg::RATE_MAX));
                ramp_pkg::ADDR_GAIN:
                    prm_q.gain <= ramp_pkg::GAIN_W'(clamp_level(pwdata,
                        ramp_pkg::GAIN_MIN, ramp_pkg::GAIN_MAX));
                ramp_pkg::ADDR_OFFSET:
                    prm_q.offset <= clamp_level(pwdata,
                        ramp_pkg::OFFSET_MIN, ramp_pkg::OFFSET_MAX);
                default:
                    ; // Read-only or unmapped: write ignored
            endcase
        end
    end

    // Read decode
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_data = '0;
        unique case (paddr)
            ramp_pkg::ADDR_CTRL:
            begin
                rd_data[ramp_pkg::CTRL_SRC1_BIT] = prm_q.src1_ext;
                rd_data[ramp_pkg::CTRL_SRC2_BIT] = prm_q.src2_ext;
            end
            ramp_pkg::ADDR_TARGET1: rd_data = 32'(prm_q.target_one);
            ramp_pkg::ADDR_TARGET2: rd_data = 32'(prm_q.target_two);
            ramp_pkg::ADDR_CEILING: rd_data = 32'(prm_q.level_ceiling);
            ramp_pkg::ADDR_LAUNCH:  rd_data = 32'(prm_q.launch_floor_offset);
            ramp_pkg::ADDR_RATE:    rd_data = 32'(prm_q.rate);
            ramp_pkg::ADDR_GAIN:    rd_data = 32'(prm_q.gain);
            ramp_pkg::ADDR_OFFSET:  rd_data = 32'(prm_q.offset);
            ramp_pkg::ADDR_STATUS:  rd_data = {28'h0000000, halt_lock_q,
                                               state_q};
            ramp_pkg::ADDR_LEVEL:   rd_data = 32'(current_level);
            ramp_pkg::ADDR_OUTPUT:  rd_data = 32'(scaled_output);
            default:                rd_hit  = 1'b0;
        endcase
    end

    // Read data and error registered for the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata  <= pwrite ? 32'h00000000 : rd_data;
            pslverr <= !rd_hit;
        end
        else
        begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

    // ==========================================================
    // Update tick
    // ==========================================================
    logic [31:0] tick_cnt_q;
    logic        tick_q;
    logic        tick_restart;

    // Restarting makes each dwell state last one full tick plus one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end
        else if (tick_restart)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end
        else if (tick_cnt_q == 32'(TICK_CYCLES - 1))
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q     <= 1'b0;
        end
    end

    // ==========================================================
    // Ramp sequencer
    // ==========================================================
    logic             enable_q;
    logic             halt_q;
    logic             en_rise;
    logic             en_fall;
    logic             halt_rise;
    ramp_pkg::level_t launch_level;
    ramp_pkg::level_t target_raw;
    ramp_pkg::level_t target_cap;
    ramp_pkg::level_t floor_cap;
    ramp_pkg::level_t step;
    ramp_pkg::level_t run_next;
    ramp_pkg::level_t halt_next;

    assign en_rise   = enable && !enable_q;
    assign en_fall   = !enable && enable_q;
    assign halt_rise = soft_halt && !halt_q;

    assign launch_level = prm_q.offset + prm_q.launch_floor_offset;

    // Target pick; external sources track another block's value
    always_comb
    begin
        if (!level_choice)
            target_raw = prm_q.src1_ext ? target_one_ext
                                        : prm_q.target_one;
        else
            target_raw = prm_q.src2_ext ? target_two_ext
                                        : prm_q.target_two;
    end

    // Targets and launch level above the ceiling are cut; the offset level loaded in idle is not
    assign target_cap = (target_raw > prm_q.level_ceiling) ?
                        prm_q.level_ceiling : target_raw;
    assign floor_cap  = (launch_level > prm_q.level_ceiling) ?
                        prm_q.level_ceiling : launch_level;

    // Tenth of the rate per tick; slow rates still creep by one
    assign step = (prm_q.rate < ramp_pkg::RATE_W'(ramp_pkg::TICKS_PER_SEC)) ?
                  ramp_pkg::level_t'(1) :
                  ramp_pkg::level_t'(prm_q.rate /
                      ramp_pkg::RATE_W'(ramp_pkg::TICKS_PER_SEC));

    assign run_next  = step_toward(current_level, target_cap, step);
    assign halt_next = step_toward(current_level, floor_cap, step);

    assign tick_restart = (en_rise && !halt_lock_q)
                       || (state_q == ramp_pkg::ST_HALT_RAMP && tick_q
                           && halt_next == floor_cap);

    // Input edge history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q <= 1'b0;
            halt_q   <= 1'b0;
        end
        else
        begin
            enable_q <= enable;
            halt_q   <= soft_halt;
        end
    end

    // Restart lock after a soft halt, cleared once both inputs drop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            halt_lock_q <= 1'b0;
        else if (halt_rise && state_q != ramp_pkg::ST_IDLE)
            halt_lock_q <= 1'b1;
        else if (!enable && !soft_halt)
            halt_lock_q <= 1'b0;
    end

    // State and level; enable fall beats every other event
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q       <= ramp_pkg::ST_IDLE;
            current_level <= '0;
        end
        else if (en_fall)
        begin
            state_q       <= ramp_pkg::ST_IDLE;
            current_level <= prm_q.offset;
        end
        else
        begin
            unique case (state_q)
                ramp_pkg::ST_IDLE:
                begin
                    current_level <= prm_q.offset;
                    if (en_rise && !halt_lock_q)
                    begin
                        state_q       <= ramp_pkg::ST_START_DWELL;
                        current_level <= floor_cap;
                    end
                end
                ramp_pkg::ST_START_DWELL:
                begin
                    if (halt_rise)
                        state_q <= ramp_pkg::ST_HALT_RAMP;
                    else if (tick_q)
                        state_q <= ramp_pkg::ST_RAMP;
                end
                ramp_pkg::ST_RAMP:
                begin
                    // Choice change simply swaps the target mid-ramp
                    if (halt_rise)
                        state_q <= ramp_pkg::ST_HALT_RAMP;
                    else if (tick_q)
                        current_level <= run_next;
                end
                ramp_pkg::ST_HALT_RAMP:
                begin
                    if (tick_q)
                    begin
                        current_level <= halt_next;
                        if (halt_next == floor_cap)
                            state_q <= ramp_pkg::ST_HALT_DWELL;
                    end
                end
                ramp_pkg::ST_HALT_DWELL:
                begin
                    if (tick_q)
                    begin
                        state_q       <= ramp_pkg::ST_IDLE;
                        current_level <= prm_q.offset;
                    end
                end
                default:
                    state_q <= ramp_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Scaled output
    // ==========================================================
    logic signed [ramp_pkg::LEVEL_W:0] diff;
    logic [ramp_pkg::DIV_W-1:0]        dividend;
    logic [ramp_pkg::DIV_W-1:0]        quotient;
    logic [ramp_pkg::GAIN_W-1:0]       div_gain_q;
    logic                              diff_neg_q;
    logic                              div_busy;
    logic                              div_done;

    // Gain is held in hundredths, so scale the numerator to match
    assign diff = {current_level[ramp_pkg::LEVEL_W-1], current_level}
                - {prm_q.offset[ramp_pkg::LEVEL_W-1], prm_q.offset};
    assign dividend = diff[ramp_pkg::LEVEL_W] ? '0 :
                      ramp_pkg::DIV_W'(diff) *
                      ramp_pkg::DIV_W'(ramp_pkg::GAIN_SCALE);

    // Sample sign and gain with the operands the divider takes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_gain_q <= '0;
            diff_neg_q <= 1'b0;
        end
        else if (!div_busy)
        begin
            div_gain_q <= prm_q.gain;
            diff_neg_q <= diff[ramp_pkg::LEVEL_W];
        end
    end

    // Divider runs back to back; output trails the level by up to 66 cycles
    serial_divider #(
        .NUM_W (ramp_pkg::DIV_W),
        .DEN_W (ramp_pkg::GAIN_W)
    ) u_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (!div_busy),
        .dividend (dividend),
        .divisor  (prm_q.gain),
        .busy     (div_busy),
        .done     (div_done),
        .quotient (quotient)
    );

    // Clamp to the output range; zero gain saturates high unless the level is below the offset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            scaled_output <= '0;
        else if (div_done)
        begin
            if (diff_neg_q)
                scaled_output <= '0;
            else if (div_gain_q == '0
                  || quotient > ramp_pkg::DIV_W'(ramp_pkg::OUT_MAX))
                scaled_output <= ramp_pkg::OUT_W'(ramp_pkg::OUT_MAX);
            else
                scaled_output <= ramp_pkg::OUT_W'(quotient);
        end
    end

endmodule
`default_nettype wire

// *** verilog/ramp_pkg.sv ***
// Shared constants, register map and carrier types for the level ramp
package ramp_pkg;

    // ==========================================================
    // Widths and timing
    // ==========================================================
    localparam int unsigned LEVEL_W       = 18;
    localparam int unsigned OUT_W         = 16;
    localparam int unsigned RATE_W        = 14;
    localparam int unsigned GAIN_W        = 11;
    localparam int unsigned DIV_W         = 32;
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned TICK_MS       = 100;
    localparam int unsigned TICK_CYCLES   = TICK_MS * 1000 * CLK_MHZ;
    localparam int unsigned TICKS_PER_SEC = 1000 / TICK_MS;
    localparam int unsigned GAIN_SCALE    = 100;

    // ==========================================================
    // Parameter ranges
    // ==========================================================
    localparam int TARGET_MIN  = -10000;
    localparam int TARGET_MAX  = 20000;
    localparam int LAUNCH_MIN  = 0;
    localparam int LAUNCH_MAX  = 20000;
    localparam int RATE_MIN    = 1;
    localparam int RATE_MAX    = 10000;
    localparam int GAIN_MIN    = 0;
    localparam int GAIN_MAX    = 1000;
    localparam int OFFSET_MIN  = -10000;
    localparam int OFFSET_MAX  = 10000;
    localparam int OUT_MAX     = 32767;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_TARGET1 = 8'h04;
    localparam logic [7:0] ADDR_TARGET2 = 8'h08;
    localparam logic [7:0] ADDR_CEILING = 8'h0c;
    localparam logic [7:0] ADDR_LAUNCH  = 8'h10;
    localparam logic [7:0] ADDR_RATE    = 8'h14;
    localparam logic [7:0] ADDR_GAIN    = 8'h18;
    localparam logic [7:0] ADDR_OFFSET  = 8'h1c;
    localparam logic [7:0] ADDR_STATUS  = 8'h20;
    localparam logic [7:0] ADDR_LEVEL   = 8'h24;
    localparam logic [7:0] ADDR_OUTPUT  = 8'h28;

    // Control register fields
    localparam int unsigned CTRL_SRC1_BIT = 0;
    localparam int unsigned CTRL_SRC2_BIT = 1;

    // ==========================================================
    // Types
    // ==========================================================
    typedef logic signed [LEVEL_W-1:0] level_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_START_DWELL, ST_RAMP, ST_HALT_RAMP, ST_HALT_DWELL
    } ramp_state_t;

    typedef struct packed {
        logic              src1_ext;
        logic              src2_ext;
        level_t            target_one;
        level_t            target_two;
        level_t            level_ceiling;
        level_t            launch_floor_offset;
        logic [RATE_W-1:0] rate;
        logic [GAIN_W-1:0] gain;
        level_t            offset;
    } ramp_params_t;

    // Reset values of the parameter set
    localparam level_t            RST_CEILING = level_t'(TARGET_MAX);
    localparam logic [RATE_W-1:0] RST_RATE    = RATE_W'(10);
    localparam logic [GAIN_W-1:0] RST_GAIN    = GAIN_W'(GAIN_SCALE);

endpackage

// *** verilog/serial_divider.sv ***
// Serial restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module serial_divider #(
    parameter int unsigned NUM_W = 32,
    parameter int unsigned DEN_W = 11
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             start,
    input  wire logic [NUM_W-1:0] dividend,
    input  wire logic [DEN_W-1:0] divisor,
    output logic                  busy,
    output logic                  done,
    output logic [NUM_W-1:0]      quotient
);

    localparam int unsigned CNT_W = $clog2(NUM_W + 1);

    logic [NUM_W-1:0] rem_q;
    logic [NUM_W-1:0] num_q;
    logic [DEN_W-1:0] den_q;
    logic [CNT_W-1:0] cnt_q;
    logic [NUM_W-1:0] trial;

    // Shift the next numerator bit into the partial remainder
    assign trial = {rem_q[NUM_W-2:0], num_q[NUM_W-1]};

    // One iteration per cycle; a zero divisor yields all ones
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rem_q    <= '0;
            num_q    <= '0;
            den_q    <= '0;
            cnt_q    <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
            quotient <= '0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                rem_q <= '0;
                num_q <= dividend;
                den_q <= divisor;
                cnt_q <= CNT_W'(NUM_W);
                busy  <= 1'b1;
            end
            else if (busy)
            begin
                num_q <= {num_q[NUM_W-2:0], 1'b0};
                if (trial >= NUM_W'(den_q))
                begin
                    rem_q    <= trial - NUM_W'(den_q);
                    quotient <= {quotient[NUM_W-2:0], 1'b1};
                end
                else
                begin
                    rem_q    <= trial;
                    quotient <= {quotient[NUM_W-2:0], 1'b0};
                end
                cnt_q <= cnt_q - CNT_W'(1);
                if (cnt_q == CNT_W'(1))
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire
